// ===== dbgsup_top.sv
// Purpose: support control word with debug strobes, dma request pin and buffer byte swap
// Assumes: mclk_i serves as the ram clock; event inputs are single-cycle pulses
// Notes:   swap paths are registered, so buffer data lags one cycle
//
// The APB register port was left to the implementer.

// Overview of operation
// - one 32-bit word at offset 0x0008
// - strobe enables high half, dma low half
// - bit31 gates four buffer update strobes
// - bit30 gates cycle start strobe
// - bit29 gates macrotick start strobe
// - bit28 gates dynamic segment start strobe
// - bit27 gates cycle zero start strobe
// - reserved bits read zero, host writes zero
// - swap clear passes buffer data unchanged
// - swap in clock modes reverses four bytes
// - swap in halfword mode exchanges byte pairs
// - no swapping in serial bus mode
// - bit2 selects request active level
// - requests only while request enable set
// - polarity and enable matter only when driven
// - bit0 drives pin, otherwise released
module dbgsup_top
  import dbgsup_pkg::*;
(
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [dbgsup_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  input  wire logic [3:0]                  pstrb_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire dbgsup_pkg::dbgsup_mode_t    bus_mode_i,
  input  wire logic [3:0]                  buf_update_evt_i,
  input  wire logic                        cycle_start_evt_i,
  input  wire logic                        tick_start_evt_i,
  input  wire logic                        dyn_segment_evt_i,
  input  wire logic                        cycle_zero_evt_i,
  input  wire logic                        dma_request_evt_i,
  output logic                             rx1_buffer_update_strobe_o,
  output logic                             rx2_buffer_update_strobe_o,
  output logic                             tx1_buffer_update_strobe_o,
  output logic                             tx2_buffer_update_strobe_o,
  output logic                             cycle_start_strobe_o,
  output logic                             tick_start_strobe_o,
  output logic                             dyn_segment_strobe_o,
  output logic                             cycle_zero_strobe_o,
  output logic                             dma_req_o,
  output logic                             dma_req_oe_o,
  input  wire logic [31:0]                 host_wdata_i,
  output logic      [31:0]                 buf_wdata_o,
  input  wire logic [31:0]                 buf_rdata_i,
  output logic      [31:0]                 host_rdata_o
);
  import dbgsup_pkg::*;

  logic [31:0] support_r;
  logic [31:0] support_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [7:0]  strobe_r;
  logic [7:0]  strobe_nxt;
  logic        dma_req_r;
  logic        dma_req_nxt;
  logic        dma_oe_r;
  logic        dma_oe_nxt;
  logic [31:0] buf_wdata_r;
  logic [31:0] buf_wdata_nxt;
  logic [31:0] host_rdata_r;
  logic [31:0] host_rdata_nxt;
  logic        hit;
  logic        setup;
  logic        swap_full;
  logic        swap_half;

  // apb slave: one wait-free access phase, pready answered the cycle after setup
  assign setup = psel_i && !penable_i;
  assign hit   = (paddr_i == SUPPORT_WORD_ADDR);

  always_comb begin
    support_nxt = support_r;
    prdata_nxt  = 32'h00000000;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pready_nxt  = 1'b1;
      // partial strobes refused: word is full-width only
      pslverr_nxt = !hit || (pwrite_i && (pstrb_i != 4'hF));
      if (hit && !pwrite_i) begin
        prdata_nxt = support_r & SUPPORT_WRITE_MASK;
      end
    end
    // write lands at the completing edge, i.e. pready high
    if (psel_i && penable_i && pready_r && pwrite_i && !pslverr_r) begin
      support_nxt = pwdata_i & SUPPORT_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      support_r <= SUPPORT_RESET;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      support_r <= support_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // debug strobes, one cycle high per event, low while disabled
  always_comb begin
    strobe_nxt[3:0] = buf_update_evt_i & {4{support_r[BUF_UPDATE_BIT]}};
    strobe_nxt[4]   = cycle_start_evt_i && support_r[CYC_START_BIT];
    strobe_nxt[5]   = tick_start_evt_i && support_r[TICK_START_BIT];
    strobe_nxt[6]   = dyn_segment_evt_i && support_r[DYN_SEG_BIT];
    strobe_nxt[7]   = cycle_zero_evt_i && support_r[CYC_ZERO_BIT];
  end

  // dma request pin: enable gate then polarity xor, released when not driven
  always_comb begin
    dma_oe_nxt  = support_r[DMA_PIN_OE_BIT];
    dma_req_nxt = 1'b0;
    if (support_r[DMA_PIN_OE_BIT]) begin
      dma_req_nxt = (dma_request_evt_i && support_r[DMA_REQ_EN_BIT])
                    ^ support_r[DMA_POL_BIT];
    end
  end

  // byte swap; serial mode ignores the swap bit
  assign swap_full = support_r[SWAP_BIT] &&
                     ((bus_mode_i == DBGSUP_MODE_RISE) ||
                      (bus_mode_i == DBGSUP_MODE_FALL));
  assign swap_half = support_r[SWAP_BIT] && (bus_mode_i == DBGSUP_MODE_HALFWORD);

  always_comb begin
    buf_wdata_nxt  = host_wdata_i;
    host_rdata_nxt = buf_rdata_i;
    if (swap_full) begin
      buf_wdata_nxt  = {host_wdata_i[7:0], host_wdata_i[15:8],
                        host_wdata_i[23:16], host_wdata_i[31:24]};
      host_rdata_nxt = {buf_rdata_i[7:0], buf_rdata_i[15:8],
                        buf_rdata_i[23:16], buf_rdata_i[31:24]};
    end else if (swap_half) begin
      buf_wdata_nxt  = {host_wdata_i[23:16], host_wdata_i[31:24],
                        host_wdata_i[7:0], host_wdata_i[15:8]};
      host_rdata_nxt = {buf_rdata_i[23:16], buf_rdata_i[31:24],
                        buf_rdata_i[7:0], buf_rdata_i[15:8]};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_r     <= 8'h00;
      dma_req_r    <= 1'b0;
      dma_oe_r     <= 1'b0;
      buf_wdata_r  <= 32'h00000000;
      host_rdata_r <= 32'h00000000;
    end else begin
      strobe_r     <= strobe_nxt;
      dma_req_r    <= dma_req_nxt;
      dma_oe_r     <= dma_oe_nxt;
      buf_wdata_r  <= buf_wdata_nxt;
      host_rdata_r <= host_rdata_nxt;
    end
  end

  assign prdata_o                   = prdata_r;
  assign pready_o                   = pready_r;
  assign pslverr_o                  = pslverr_r;
  assign rx1_buffer_update_strobe_o = strobe_r[0];
  assign rx2_buffer_update_strobe_o = strobe_r[1];
  assign tx1_buffer_update_strobe_o = strobe_r[2];
  assign tx2_buffer_update_strobe_o = strobe_r[3];
  assign cycle_start_strobe_o       = strobe_r[4];
  assign tick_start_strobe_o        = strobe_r[5];
  assign dyn_segment_strobe_o       = strobe_r[6];
  assign cycle_zero_strobe_o        = strobe_r[7];
  assign dma_req_o                  = dma_req_r;
  assign dma_req_oe_o               = dma_oe_r;
  assign buf_wdata_o                = buf_wdata_r;
  assign host_rdata_o               = host_rdata_r;
endmodule : dbgsup_top

// ===== dbgsup_pkg.sv
// Purpose: constants for the debug strobe and dma support register block
// Assumes: apb slave, 32-bit data, one clock
// Notes:   field positions of the combined support word
package dbgsup_pkg;
  localparam logic [11:0] SUPPORT_WORD_ADDR   = 12'h008;
  localparam int          ADDR_W              = 12;
  localparam int          BUF_UPDATE_BIT      = 31;
  localparam int          CYC_START_BIT       = 30;
  localparam int          TICK_START_BIT      = 29;
  localparam int          DYN_SEG_BIT         = 28;
  localparam int          CYC_ZERO_BIT        = 27;
  localparam int          SWAP_BIT            = 3;
  localparam int          DMA_POL_BIT         = 2;
  localparam int          DMA_REQ_EN_BIT      = 1;
  localparam int          DMA_PIN_OE_BIT      = 0;
  localparam logic [31:0] SUPPORT_WRITE_MASK  = 32'hF800000F;
  localparam logic [31:0] SUPPORT_RESET       = 32'h00000000;
  // host bus mode encodings
  typedef enum logic [1:0] {
    DBGSUP_MODE_RISE     = 2'b00,
    DBGSUP_MODE_FALL     = 2'b01,
    DBGSUP_MODE_HALFWORD = 2'b10,
    DBGSUP_MODE_SERIAL   = 2'b11
  } dbgsup_mode_t;
endpackage : dbgsup_pkg

// ===== dbgsup_monitor.sv
// Purpose: port checker for the support word block
// Assumes: no apb wait states
// Notes:   strobe checks look one edge back, the segment strobe check one edge ahead
module dbgsup_monitor
  import dbgsup_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        dma_req_o,
  input wire logic        dma_req_oe_o,
  input wire logic [3:0]  buf_update_evt_i,
  input wire logic        cycle_start_evt_i,
  input wire logic        tick_start_evt_i,
  input wire logic        dyn_segment_evt_i,
  input wire logic        tx2_buffer_update_strobe_o,
  input wire logic        cycle_start_strobe_o,
  input wire logic        tick_start_strobe_o,
  input wire logic        dyn_segment_strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_RDY: assert property (psel_i && !penable_i |=> pready_o && psel_i)
    else $error("no answer after setup");
  AST_ERR: assert property (pready_o && paddr_i != SUPPORT_WORD_ADDR |-> pslverr_o)
    else $error("unmapped address accepted");
  AST_RSV: assert property (pready_o && !pwrite_i |-> prdata_o[26:4] == '0)
    else $error("reserved bits not zero");
  AST_OE: assert property (!dma_req_oe_o |-> !dma_req_o)
    else $error("request driven while released");
  AST_CYC: assert property (cycle_start_strobe_o |-> $past(cycle_start_evt_i))
    else $error("cycle strobe without event");
  AST_TICK: assert property (tick_start_strobe_o |-> $past(tick_start_evt_i))
    else $error("tick strobe without event");
  AST_DYN: assert property (dyn_segment_strobe_o |=> !dyn_segment_strobe_o)
    else $error("segment strobe longer than one cycle");
  AST_BUF: assert property (tx2_buffer_update_strobe_o |-> $past(buf_update_evt_i[3]))
    else $error("buffer strobe without event");
endmodule : dbgsup_monitor
bind dbgsup_top dbgsup_monitor dbgsup_monitor_i (.*);

// ===== dbgsup_host.sv
// Purpose: host side of the request pin
// Assumes: host input has a pull-up
// Notes:   released pin reads high, never the last value
module dbgsup_host (
  input  wire logic req_i,
  input  wire logic oe_i,
  output wire logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_o = oe_i ? req_i : 1'h1;
endmodule : dbgsup_host

// ===== debug_strobe_dma_support_tb.sv
// Purpose: register, strobe, dma pin and swap tests
// Assumes: apb master changes signals after rising edges
// Notes:   pstrb full except one refused partial write
module debug_strobe_dma_support_tb;
  import dbgsup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, dma_request_evt_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, host_wdata_i = 32'h11223344, buf_rdata_i = 32'hA1B2C3D4;
  logic [3:0] pstrb_i = 4'hF;
  logic [7:0] ev = '0;
  // expected strobe vector per enable pattern, all, each bit alone, none
  localparam logic [55:0] SV_EXP = 56'hFFF00804020100;
  dbgsup_mode_t bus_mode_i = DBGSUP_MODE_RISE;
  wire [3:0] buf_update_evt_i = ev[7:4];
  wire cycle_start_evt_i = ev[3], tick_start_evt_i = ev[2];
  wire dyn_segment_evt_i = ev[1], cycle_zero_evt_i = ev[0];
  logic [31:0] prdata_o, buf_wdata_o, host_rdata_o;
  logic pready_o, pslverr_o, rx1_buffer_update_strobe_o, rx2_buffer_update_strobe_o;
  logic tx1_buffer_update_strobe_o, tx2_buffer_update_strobe_o, cycle_start_strobe_o;
  logic tick_start_strobe_o, dyn_segment_strobe_o, cycle_zero_strobe_o, dma_req_o, dma_req_oe_o;
  wire pin;
  wire [7:0] sv = {rx1_buffer_update_strobe_o, rx2_buffer_update_strobe_o,
    tx1_buffer_update_strobe_o, tx2_buffer_update_strobe_o, cycle_start_strobe_o,
    tick_start_strobe_o, dyn_segment_strobe_o, cycle_zero_strobe_o};
  int failures = 0, samples_checked = 0;
  dbgsup_top dbgsup_top_i (.*);
  dbgsup_host dbgsup_host_i (.req_i(dma_req_o), .oe_i(dma_req_oe_o), .pin_o(pin));
  always #5 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, x, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // waits on pready only, the slave sets the pace; idle edge first, no double drive
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  function automatic logic [31:0] swp(input logic [31:0] d, input int m, input logic s);
    if (!s || m == 3) return d;
    if (m == 2) return {d[23:16], d[31:24], d[7:0], d[15:8]};
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swp
  initial begin
    logic [31:0] r;
    logic e;
    logic [31:0] wv;
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    apb(1'b0, 12'h008, '0, r, e);
    chk("reset word", r, SUPPORT_RESET);
    apb(1'b1, 12'h008, '1, r, e);
    chk("write ok", 32'(e), 32'h0);
    apb(1'b0, 12'h008, '0, r, e);
    chk("writable bits", r, SUPPORT_WRITE_MASK);
    pstrb_i <= 4'h3;
    apb(1'b1, 12'h008, '0, r, e);
    chk("partial write error", 32'(e), 32'h1);
    pstrb_i <= 4'hF;
    apb(1'b0, 12'h008, '0, r, e);
    chk("partial write ignored", r, SUPPORT_WRITE_MASK);
    apb(1'b0, 12'h00C, '0, r, e);
    chk("unmapped error", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
    for (int k = 0; k < 7; k++) begin
      wv = (k == 0) ? 32'hF8000000 : (k == 6) ? 32'h0 : 32'h80000000 >> (k - 1);
      apb(1'b1, 12'h008, wv, r, e);
      @(posedge mclk_i) ev <= '1;
      @(posedge mclk_i) ev <= '0;
      @(negedge mclk_i) chk("strobes", 32'(sv), 32'(SV_EXP[(6 - k) * 8 +: 8]));
      @(negedge mclk_i) chk("strobe width", 32'(sv), 32'h0);
      @(posedge mclk_i);
    end
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, 12'h008, 32'(i[3:0]), r, e);
      chk("write ok", 32'(e), 32'h0);
      bus_mode_i <= dbgsup_mode_t'(i[5:4]);
      dma_request_evt_i <= i[4];
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("dma pin", 32'(pin), i[0] ? 32'((i[4] & i[1]) ^ i[2]) : 32'h1);
      chk("dma oe", 32'(dma_req_oe_o), 32'(i[0]));
      chk("buf wdata", buf_wdata_o, swp(host_wdata_i, i / 16, i[3]));
      chk("host rdata", host_rdata_o, swp(buf_rdata_i, i / 16, i[3]));
      @(posedge mclk_i);
    end
    tally_and_finish;
  end
  initial begin
    #50000;
    failures++;
    tally_and_finish;
  end
endmodule : debug_strobe_dma_support_tb
